// >>> rtl/afc_pkg.sv
// Purpose: Constants for the converter sequencer and compare window block
// Assumes: Classic Wishbone, 32-bit data, byte addresses
// Notes:   Offsets are chosen locally; fields follow the extended mode layout
package afc_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_MODE   = 8'h04;
    localparam logic [7:0] OFF_SEQ_LO = 8'h08;
    localparam logic [7:0] OFF_SEQ_HI = 8'h0c;
    localparam logic [7:0] OFF_CHEN   = 8'h18;
    localparam logic [7:0] OFF_LCDR   = 8'h20;
    localparam logic [7:0] OFF_ISR    = 8'h30;
    localparam logic [7:0] OFF_IMR    = 8'h34;
    localparam logic [7:0] OFF_EMR    = 8'h38;
    localparam logic [7:0] OFF_CWR    = 8'h3c;
    localparam logic [7:0] OFF_DIFFERENTIAL_SELECT   = 8'h40;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int MODE_USER_SEQ = 31;
    localparam int MODE_TRG_EN   = 0;
    localparam int MODE_TRG_SEL  = 1;
    localparam int EMR_KIND_LO   = 0;
    localparam int EMR_SEL_LO    = 3;
    localparam int EMR_ALL       = 9;
    localparam int EMR_FILT_LO   = 12;
    localparam int EMR_RESOL_LO  = 16;
    localparam int EMR_TAG       = 24;
    localparam int EMR_SIGN_LO   = 25;
    localparam int CWR_HIGH_LO   = 16;
    localparam int ISR_WINDOW    = 26;
    localparam int ISR_DONE      = 24;
    localparam int LCDR_TAG_LO   = 24;
    localparam int SLOTS         = 12;
    localparam int SLOT_W        = 4;
    localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
    // ------------------------------------------------------------
    // Resolution and compare encodings
    // ------------------------------------------------------------
    localparam logic [2:0] RESOL_PLAIN12 = 3'h0;
    localparam logic [2:0] RESOL_TEN     = 3'h1;
    localparam logic [1:0] CMP_LOW     = 2'h0;
    localparam logic [1:0] CMP_HIGH    = 2'h1;
    localparam logic [1:0] CMP_IN      = 2'h2;
    localparam logic [1:0] CMP_OUT     = 2'h3;
    localparam logic [1:0] SIGN_ALL_UNSIGNED = 2'h2;
    localparam logic [1:0] SIGN_ALL_SIGNED   = 2'h3;
    typedef enum logic [1:0] {S_IDLE, S_START, S_WAIT, S_NEXT} afc_state_t;
endpackage

// >>> rtl/afc_analog_front_end_ctrl.sv
// Purpose: Sequencer, averaging, channel tag and window comparator of the converter
// Assumes: Analog core takes a channel and start, returns a 12-bit sample with done
// Notes:   Registers on classic Wishbone, one cycle ack
//
// Operation
// RULE_01 - With user sequence on, convert in order of the twelve sequence slots
// RULE_02 - Slots may hold any channels, repeated channels convert once per slot
// RULE_03 - A slot whose channel is disabled is skipped; the code tests the enable bit indexed by slot number, not by channel
// RULE_04 - Sequences start from a timer output or the PWM event line
// RULE_05 - Slot order applies only when user sequence enable is set
// RULE_06 - Each result raises a DMA request, cleared by reading the result
// RULE_07 - Compare kind: below low, above high, inside, outside window
// RULE_08 - Compare every channel bit compares all channels, else selected one
// RULE_09 - Compared channel select chooses the channel only when not comparing all
// RULE_10 - Flag rises after filter value plus one consecutive events
// RULE_11 - Flag shows in interrupt status and requests interrupt when enabled
// RULE_12 - One read/write register holds low and high thresholds
// RULE_13 - Software programs thresholds in the same signedness as results
// RULE_14 - Comparing all channels needs all-signed or all-unsigned interpretation
// RULE_15 - Differential select bit 0 single-ended, 1 differential, reset single-ended
// RULE_16 - Each channel has its own single-ended or differential setting
// RULE_17 - Resolution field picks 12, 10 bits or 4 to 256 sample averages
// RULE_18 - Channel tag enable appends channel number to last result, else zero
// RULE_19 - A compared result that misses the condition restarts the event count
// RULE_20 - Compare follows averaging, with that channel's sign interpretation
//
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
module afc_analog_front_end_ctrl #(
    parameter int CHANNELS = 12
) (
    // System
    input  wire logic        clock,
    input  wire logic        rst_b,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Trigger sources, asynchronous
    input  wire logic        timer_trigger,
    input  wire logic        pwm_event,
    // Analog core
    output logic      [4:0]  conv_channel,
    output logic             conv_differential,
    output logic             conv_start,
    input  wire logic        conv_done,
    input  wire logic [11:0] conv_sample,
    // System requests
    output logic             dma_request,
    output logic             irq
);
    initial begin
        if (CHANNELS < 1 || CHANNELS > 16)
            $error("CHANNELS must be 1 to 16");
    end

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [31:0] mode_reg, seq_lo_reg, seq_hi_reg, chen_reg, emr_reg, cwr_reg, differential_select_reg;
    logic [31:0] lcdr_reg, imr_reg;
    logic        flag_reg, done_reg, ack_reg;
    logic        bus_wr, bus_rd;
    logic        flag_set;

    // Write lands on the edge at which the master samples ack high
    assign bus_wr   = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
    assign bus_rd   = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_reg;
    assign wb_ack_o = ack_reg;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        return r;
    endfunction

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mode_reg   <= afc_pkg::RESET_ZERO;
            seq_lo_reg <= afc_pkg::RESET_ZERO;
            seq_hi_reg <= afc_pkg::RESET_ZERO;
            chen_reg   <= afc_pkg::RESET_ZERO;
            emr_reg    <= afc_pkg::RESET_ZERO;
            cwr_reg    <= afc_pkg::RESET_ZERO;
            differential_select_reg   <= afc_pkg::RESET_ZERO;   // see RULE_15
            imr_reg    <= afc_pkg::RESET_ZERO;
        end else if (bus_wr) begin
            unique case (wb_adr_i)
                afc_pkg::OFF_MODE:   mode_reg   <= merge(mode_reg, wb_dat_i, wb_sel_i);
                afc_pkg::OFF_SEQ_LO: seq_lo_reg <= merge(seq_lo_reg, wb_dat_i, wb_sel_i);
                afc_pkg::OFF_SEQ_HI: seq_hi_reg <= merge(seq_hi_reg, wb_dat_i, wb_sel_i);
                afc_pkg::OFF_CHEN:   chen_reg   <= merge(chen_reg, wb_dat_i, wb_sel_i);
                afc_pkg::OFF_EMR:    emr_reg    <= merge(emr_reg, wb_dat_i, wb_sel_i);
                afc_pkg::OFF_CWR:    cwr_reg    <= merge(cwr_reg, wb_dat_i, wb_sel_i); // see RULE_12
                afc_pkg::OFF_DIFFERENTIAL_SELECT:   differential_select_reg   <= merge(differential_select_reg, wb_dat_i, wb_sel_i); // see RULE_16
                afc_pkg::OFF_IMR:    imr_reg    <= merge(imr_reg, wb_dat_i, wb_sel_i);
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ack_reg  <= 1'b0;
            wb_dat_o <= afc_pkg::RESET_ZERO;
        end else begin
            ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
            unique case (wb_adr_i)
                afc_pkg::OFF_MODE:   wb_dat_o <= mode_reg;
                afc_pkg::OFF_SEQ_LO: wb_dat_o <= seq_lo_reg;
                afc_pkg::OFF_SEQ_HI: wb_dat_o <= seq_hi_reg;
                afc_pkg::OFF_CHEN:   wb_dat_o <= chen_reg;
                afc_pkg::OFF_LCDR:   wb_dat_o <= lcdr_reg;
                afc_pkg::OFF_ISR: begin
                    wb_dat_o <= afc_pkg::RESET_ZERO;
                    wb_dat_o[afc_pkg::ISR_WINDOW] <= flag_reg;   // see RULE_11
                    wb_dat_o[afc_pkg::ISR_DONE]   <= done_reg;
                end
                afc_pkg::OFF_IMR:    wb_dat_o <= imr_reg;
                afc_pkg::OFF_EMR:    wb_dat_o <= emr_reg;
                afc_pkg::OFF_CWR:    wb_dat_o <= cwr_reg;
                afc_pkg::OFF_DIFFERENTIAL_SELECT:   wb_dat_o <= differential_select_reg;
                default:             wb_dat_o <= afc_pkg::RESET_ZERO;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Trigger synchronisers
    // ------------------------------------------------------------
    logic [1:0] tmr_sync, pwm_sync;
    logic       trig_last;
    logic       trig_level, trig_rise;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tmr_sync  <= 2'h0;
            pwm_sync  <= 2'h0;
            trig_last <= 1'b0;
        end else begin
            tmr_sync  <= {tmr_sync[0], timer_trigger};
            pwm_sync  <= {pwm_sync[0], pwm_event};
            trig_last <= trig_level;
        end
    end

    assign trig_level = mode_reg[afc_pkg::MODE_TRG_SEL] ? pwm_sync[1] : tmr_sync[1]; // see RULE_04
    assign trig_rise  = mode_reg[afc_pkg::MODE_TRG_EN] && trig_level && !trig_last;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    afc_pkg::afc_state_t state_reg;
    logic [3:0]  slot_reg;
    logic [4:0]  chan_reg;
    logic [8:0]  avg_cnt_reg;
    logic [19:0] acc_reg;
    logic        user_order;
    logic [3:0]  slot_chan;
    logic [2:0]  resol;
    logic [8:0]  avg_total;
    logic        acc_last;

    assign user_order = mode_reg[afc_pkg::MODE_USER_SEQ];
    assign resol      = emr_reg[afc_pkg::EMR_RESOL_LO +: 3];

    // Channel held in a slot when user order is on, else slot number itself;
    // all sources are arguments so the assignment follows register writes
    function automatic logic [3:0] slot_to_chan(input logic [3:0] s, input logic [63:0] all,
                                                input logic user);
        return user ? all[s*afc_pkg::SLOT_W +: afc_pkg::SLOT_W] : s; // see RULE_01 RULE_05
    endfunction

    assign slot_chan = slot_to_chan(slot_reg, {seq_hi_reg, seq_lo_reg}, user_order);

    always_comb begin
        unique case (resol)
            3'h2:    avg_total = 9'h004;
            3'h3:    avg_total = 9'h010;
            3'h4:    avg_total = 9'h040;
            3'h5:    avg_total = 9'h100;
            default: avg_total = 9'h001;
        endcase
    end
    assign acc_last = (avg_cnt_reg + 9'h001) == avg_total;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_reg   <= afc_pkg::S_IDLE;
            slot_reg    <= 4'h0;
            chan_reg    <= 5'h00;
            avg_cnt_reg <= 9'h000;
        end else begin
            unique case (state_reg)
                afc_pkg::S_IDLE: if (trig_rise) begin
                    slot_reg  <= 4'h0;
                    state_reg <= afc_pkg::S_NEXT;
                end
                afc_pkg::S_NEXT: begin
                    if (slot_reg >= 4'(afc_pkg::SLOTS)) state_reg <= afc_pkg::S_IDLE;
                    else if (chen_reg[slot_reg] && int'(slot_chan) < CHANNELS) begin
                        chan_reg    <= {1'b0, slot_chan};   // see RULE_02
                        avg_cnt_reg <= 9'h000;
                        state_reg   <= afc_pkg::S_START;
                    end else slot_reg <= slot_reg + 4'h1;   // see RULE_03
                end
                afc_pkg::S_START: state_reg <= afc_pkg::S_WAIT;
                afc_pkg::S_WAIT: if (conv_done) begin
                    if (acc_last) begin
                        slot_reg  <= slot_reg + 4'h1;
                        state_reg <= afc_pkg::S_NEXT;
                    end else begin
                        avg_cnt_reg <= avg_cnt_reg + 9'h001;
                        state_reg   <= afc_pkg::S_START;
                    end
                end
            endcase
        end
    end

    assign conv_start        = state_reg == afc_pkg::S_START;
    assign conv_channel      = chan_reg;
    assign conv_differential = differential_select_reg[chan_reg];   // see RULE_15 RULE_16

    // ------------------------------------------------------------
    // Averaging and result
    // ------------------------------------------------------------
    logic [19:0] acc_sum;
    logic [15:0] result;
    logic        result_valid;

    assign acc_sum      = (avg_cnt_reg == 9'h000 ? 20'h00000 : acc_reg) + {8'h00, conv_sample};
    assign result_valid = state_reg == afc_pkg::S_WAIT && conv_done && acc_last;

    always_comb begin   // see RULE_17
        unique case (resol)
            afc_pkg::RESOL_PLAIN12: result = {4'h0, acc_sum[11:0]};
            afc_pkg::RESOL_TEN:     result = {6'h00, acc_sum[11:2]};
            3'h2:                 result = {3'h0, acc_sum[13:1]};
            3'h3:                 result = {2'h0, acc_sum[15:2]};
            3'h4:                 result = {1'h0, acc_sum[17:3]};
            3'h5:                 result = acc_sum[19:4];
            default:              result = {4'h0, acc_sum[11:0]};
        endcase
    end

    logic lcdr_read;
    assign lcdr_read = bus_rd && wb_adr_i == afc_pkg::OFF_LCDR;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            acc_reg  <= 20'h00000;
            lcdr_reg <= afc_pkg::RESET_ZERO;
            done_reg <= 1'b0;
        end else begin
            if (state_reg == afc_pkg::S_WAIT && conv_done) acc_reg <= acc_sum;
            if (result_valid) begin
                lcdr_reg <= {3'h0, emr_reg[afc_pkg::EMR_TAG] ? chan_reg : 5'h00,
                             8'h00, result};   // see RULE_18
            end
            if (result_valid) done_reg <= 1'b1;   // see RULE_06
            else if (lcdr_read) done_reg <= 1'b0;
        end
    end
    assign dma_request = done_reg;   // see RULE_06

    // ------------------------------------------------------------
    // Window comparator
    // ------------------------------------------------------------
    logic [1:0]  kind, filt, cnt_reg, sign_mode;
    logic        compared, signed_cmp, below, above, hit;
    logic [15:0] low_th, high_th;
    logic        isr_read;

    assign kind      = emr_reg[afc_pkg::EMR_KIND_LO +: 2];
    assign filt      = emr_reg[afc_pkg::EMR_FILT_LO +: 2];
    assign sign_mode = emr_reg[afc_pkg::EMR_SIGN_LO +: 2];
    assign low_th    = cwr_reg[15:0];
    assign high_th   = cwr_reg[afc_pkg::CWR_HIGH_LO +: 16];
    // Signed when all-signed, when the channel is differential in mode 0, or single-ended in mode 1
    assign signed_cmp = sign_mode == afc_pkg::SIGN_ALL_SIGNED ||
                        (sign_mode == 2'h0 && differential_select_reg[chan_reg]) ||
                        (sign_mode == 2'h1 && !differential_select_reg[chan_reg]);   // see RULE_20 RULE_13
    assign compared  = emr_reg[afc_pkg::EMR_ALL] ||
                       chan_reg == emr_reg[afc_pkg::EMR_SEL_LO +: 5];  // see RULE_08 RULE_09
    assign below = signed_cmp ? $signed(result) < $signed(low_th) : result < low_th;
    assign above = signed_cmp ? $signed(result) > $signed(high_th) : result > high_th;

    always_comb begin   // see RULE_07
        unique case (kind)
            afc_pkg::CMP_LOW:  hit = below;
            afc_pkg::CMP_HIGH: hit = above;
            afc_pkg::CMP_IN:   hit = !below && !above;
            afc_pkg::CMP_OUT:  hit = below || above;
        endcase
    end

    assign flag_set = result_valid && compared && hit && cnt_reg == filt;   // see RULE_10
    assign isr_read = bus_rd && wb_adr_i == afc_pkg::OFF_ISR;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg  <= 2'h0;
            flag_reg <= 1'b0;
        end else begin
            if (result_valid && compared) begin
                if (!hit) cnt_reg <= 2'h0;                 // see RULE_19
                else if (cnt_reg == filt) cnt_reg <= 2'h0;
                else cnt_reg <= cnt_reg + 2'h1;            // see RULE_10
            end
            if (flag_set) flag_reg <= 1'b1;   // Set wins over read clear
            else if (isr_read) flag_reg <= 1'b0;
        end
    end

    assign irq = flag_reg && imr_reg[afc_pkg::ISR_WINDOW];   // see RULE_11
endmodule

// >>> bench/afc_check_sva.sv
// Purpose: Port-level checks of the converter control block
// Assumes: One clock domain, rst_b asynchronous and active low
// Notes:   Attached by bind from the testbench top file
`timescale 1ns/100ps
module afc_check (
    // System
    input wire logic        clock,
    input wire logic        rst_b,
    // Bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Converter and requests
    input wire logic        conv_start,
    input wire logic        conv_done,
    input wire logic        dma_request,
    input wire logic        irq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    property p_ack_answer;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("request not acked next cycle");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_cause;
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_unmapped;
        wb_ack_o && $past(!wb_we_i && wb_adr_i == 8'hfc) |-> wb_dat_o == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_start_waits;
        conv_start |=> !conv_start until conv_done;
    endproperty
    a_start_waits: assert property (p_start_waits) else $error("start before done");
    property p_start_pulse;
        conv_start |=> !conv_start;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start not a pulse");
    property p_dma_rise;
        $rose(dma_request) |-> $past(conv_done) || $past(conv_done, 2) || $past(conv_done, 3);
    endproperty
    a_dma_rise: assert property (p_dma_rise) else $error("dma without result");
    property p_dma_fall;
        $fell(dma_request) |-> $past(wb_cyc_i && !wb_we_i && wb_adr_i == afc_pkg::OFF_LCDR);
    endproperty
    a_dma_fall: assert property (p_dma_fall) else $error("dma dropped unread");
    property p_irq_fall;
        $fell(irq) |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped by itself");
endmodule

// >>> bench/afc_core_model.sv
// Purpose: Behavioural analog core answering start with one sample
// Assumes: DELAY+1 cycles from start to done, DELAY of 2 or more
// Notes:   Sample lines toggle between answers so stale data never looks valid
`timescale 1ns/100ps
module afc_core_model #(
    parameter int DELAY = 3
) (
    // System
    input  wire logic        clock,
    input  wire logic        rst_b,
    // Converter handshake
    input  wire logic        conv_start,
    output logic             conv_done,
    output logic      [11:0] conv_sample,
    // Level applied by the bench
    input  wire logic [11:0] level
);
    int cnt;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 0;
            conv_done <= 1'b0;
            conv_sample <= 12'h000;
        end else begin
            conv_done <= (cnt == 1);
            conv_sample <= (cnt == 1) ? level : ~conv_sample;
            if (conv_start) begin
                cnt <= DELAY;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule

// >>> bench/afc_analog_front_end_ctrl_test.sv
// Purpose: Register-level test of sequencing, tagging and window compare
// Assumes: Core model answers four cycles after each start
// Notes:   Every wait is bounded and ends the run on expiry
`timescale 1ns/100ps
module afc_analog_front_end_ctrl_test;
    localparam logic [4:0]  EXP_CH [2][3] = '{'{5'h0, 5'h2, 5'h3}, '{5'h5, 5'h5, 5'h7}};
    localparam logic [11:0] LV [8] = '{12'h050, 12'h100, 12'h400, 12'h300,
                                       12'h200, 12'h400, 12'h050, 12'h200};
    localparam int          AVG [4] = '{1, 1, 4, 16};
    localparam logic [31:0] AVQ [4] = '{32'h050, 32'h014, 32'h0a0, 32'h140};
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'hf;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, q;
    logic        ack, tmr = 1'b0, pwm = 1'b0, start, done, dif, dma, irq;
    logic [4:0]  ch;
    logic [11:0] smp, level = 12'h000;
    logic [4:0]  chans [$];
    logic        diffs [$];
    int          fail_count = 0, tests_run = 0, m, n, k;
    always #2 clock = ~clock;
    afc_analog_front_end_ctrl dut (.clock(clock), .rst_b(rst_b), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .timer_trigger(tmr), .pwm_event(pwm),
        .conv_channel(ch), .conv_differential(dif), .conv_start(start), .conv_done(done),
        .conv_sample(smp), .dma_request(dma), .irq(irq));
    afc_core_model #(.DELAY(3)) core (.clock(clock), .rst_b(rst_b), .conv_start(start),
        .conv_done(done), .conv_sample(smp), .level(level));
    always @(posedge clock) begin
        if (start === 1'b1) begin
            chans.push_back(ch);
            diffs.push_back(dif);
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic lim(input int cnt, input int cap);
        if (cnt >= cap) begin
            fail_count++;
            $display("unexpected wait: expected answer seen timeout");
            test_done();
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        i = 0;
        do begin
            @(posedge clock);
            i++;
        end while (ack !== 1'b1 && i < 100);
        lim(i, 100);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic fire(input logic use_pwm);
        @(posedge clock);
        if (use_pwm) pwm <= 1'b1;
        else tmr <= 1'b1;
        repeat (4) @(posedge clock);
        pwm <= 1'b0;
        tmr <= 1'b0;
    endtask
    task automatic conv(input logic [11:0] lv);
        int i;
        @(posedge clock);
        level <= lv;
        fire(1'b0);
        for (i = 0; i < 3000 && dma !== 1'b1; i++) @(posedge clock);
        lim(i, 3000);
        repeat (3) @(posedge clock);
        bus(1'b0, afc_pkg::OFF_LCDR, 32'h0);
        repeat (2) @(posedge clock);
        chk("dma cleared", {31'h0, dma}, 32'h0);
    endtask
    task automatic flag(input logic exp);
        chk("irq", {31'h0, irq}, {31'h0, exp});
        bus(1'b0, afc_pkg::OFF_ISR, 32'h0);
        chk("window flag", {31'h0, q[afc_pkg::ISR_WINDOW]}, {31'h0, exp});
    endtask
    initial begin
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        bus(1'b0, afc_pkg::OFF_DIFFERENTIAL_SELECT, 32'h0);
        chk("differential_select reset", q, 32'h0);
        bus(1'b0, 8'hfc, 32'h0);
        chk("unmapped", q, 32'h0);
        bus(1'b1, afc_pkg::OFF_CWR, 32'h0300_0100);
        bus(1'b0, afc_pkg::OFF_CWR, 32'h0);
        chk("thresholds", q, 32'h0300_0100);
        bus(1'b1, afc_pkg::OFF_SEQ_LO, 32'h0000_7525);
        bus(1'b1, afc_pkg::OFF_CHEN, 32'h0000_000d);
        bus(1'b1, afc_pkg::OFF_DIFFERENTIAL_SELECT, 32'h0000_0080);
        bus(1'b1, afc_pkg::OFF_EMR, 32'h0100_0000);
        for (m = 0; m < 2; m++) begin
            bus(1'b1, afc_pkg::OFF_MODE, (m == 1) ? 32'h8000_0003 : 32'h0000_0001);
            chans.delete();
            diffs.delete();
            level <= 12'h5a5;
            fire(m[0]);
            for (n = 0; n < 500 && chans.size() < 3; n++) @(posedge clock);
            lim(n, 500);
            repeat (40) @(posedge clock);
            chk("conversions", chans.size(), 32'd3);
            for (k = 0; k < 3; k++) begin
                chk("channel", {27'h0, chans[k]}, {27'h0, EXP_CH[m][k]});
                chk("differential_select", {31'h0, diffs[k]}, {31'h0, EXP_CH[m][k] == 5'h7});
            end
            bus(1'b0, afc_pkg::OFF_LCDR, 32'h0);
            chk("tagged", q, {3'h0, EXP_CH[m][2], 12'h0, 12'h5a5});
        end
        bus(1'b1, afc_pkg::OFF_MODE, 32'h0000_0001);
        bus(1'b1, afc_pkg::OFF_CHEN, 32'h0000_0001);
        bus(1'b1, afc_pkg::OFF_IMR, 32'h0400_0000);
        bus(1'b1, afc_pkg::OFF_EMR, 32'h0);
        conv(12'h123);
        chk("untagged", q, 32'h0000_0123);
        for (k = 0; k < 8; k++) begin
            bus(1'b1, afc_pkg::OFF_EMR, 32'h0400_0200 | k[2:1]);
            conv(LV[k]);
            flag(~k[0]);
        end
        bus(1'b1, afc_pkg::OFF_EMR, 32'h0400_0028);
        conv(12'h050);
        flag(1'b0);
        bus(1'b1, afc_pkg::OFF_EMR, 32'h0400_0000);
        conv(12'h050);
        flag(1'b1);
        bus(1'b1, afc_pkg::OFF_CWR, 32'h0300_ff00);
        for (k = 0; k < 2; k++) begin
            bus(1'b1, afc_pkg::OFF_EMR, {6'h0, k[0], 25'h0});
            conv(12'h050);
            flag(~k[0]);
        end
        bus(1'b1, afc_pkg::OFF_CWR, 32'h0300_0100);
        bus(1'b1, afc_pkg::OFF_EMR, 32'h0400_2200);
        for (k = 0; k < 6; k++) begin
            conv((k == 2) ? 12'h200 : 12'h050);
            flag(k == 5);
        end
        for (k = 0; k < 4; k++) begin
            bus(1'b1, afc_pkg::OFF_EMR, {13'h0, k[2:0], 16'h0});
            chans.delete();
            conv(12'h050);
            chk("samples", chans.size(), AVG[k]);
            chk("averaged", q, AVQ[k]);
        end
        test_done();
    end
endmodule
bind afc_analog_front_end_ctrl afc_check u_check (.clock(clock), .rst_b(rst_b),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conv_start(conv_start),
    .conv_done(conv_done), .dma_request(dma_request), .irq(irq));
